// file: rtl/param_host.sv
// host end: AXI4-Lite registers that split values into tagged words
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "fractal_map.svh"
module param_host (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // parameter link
  param_link_if.host link
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic fractal_pkg::tag_t first_tag(input logic [3:0] cmd);
    case (cmd)
      `CMD_A_MIN: return `TAG_A_MIN_HI;
      `CMD_A_DIFF: return `TAG_A_DIFF_HI;
      `CMD_A_LEAP: return `TAG_A_LEAP;
      `CMD_B_MIN: return `TAG_B_MIN_HI;
      `CMD_B_DIFF: return `TAG_B_DIFF_HI;
      `CMD_B_LEAP: return `TAG_B_LEAP;
      `CMD_C_REAL: return `TAG_C_REAL_HI;
      `CMD_C_IMG: return `TAG_C_IMG_HI;
      default: return `TAG_END;
    endcase
  endfunction

  function automatic logic is_pair(input logic [3:0] cmd);
    return cmd <= `CMD_C_IMG && cmd != `CMD_A_LEAP && cmd != `CMD_B_LEAP;
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic [3:0] value_hi;
  logic [31:0] value_lo;
  fractal_pkg::send_state_t state;
  fractal_pkg::tag_t cur_tag;
  fractal_pkg::value_t value;

  assign value = {value_hi, value_lo};
  assign do_write = !awready && !wready && !bvalid && state == fractal_pkg::SEND_IDLE;

  // ****************************************
  // write channels
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awready <= 1'b1;
      aw_addr_q <= 4'h0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wready <= 1'b1;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= (aw_addr_q == `REG_STATUS || aw_addr_q[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      value_hi <= 4'h0;
      value_lo <= 32'h0;
    end else if (do_write && aw_addr_q == `REG_VALUE_HI && w_strb_q[0]) begin
      value_hi <= w_data_q[3:0];
    end else if (do_write && aw_addr_q == `REG_VALUE_LO) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb_q[i]) begin
          value_lo[8*i +: 8] <= w_data_q[8*i +: 8];
        end
      end
    end
  end

  // ****************************************
  // tagged word sender
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= fractal_pkg::SEND_IDLE;
      cur_tag <= 4'h0;
      link.word_valid <= 1'b0;
      link.word <= 32'h0;
    end else begin
      case (state)
        fractal_pkg::SEND_IDLE: begin
          link.word_valid <= 1'b0;
          if (do_write && aw_addr_q == `REG_COMMAND && w_strb_q[0]) begin
            cur_tag <= first_tag(w_data_q[3:0]);
            state <= is_pair(w_data_q[3:0]) ? fractal_pkg::SEND_HI : fractal_pkg::SEND_LO;
          end
        end
        fractal_pkg::SEND_HI: begin
          link.word_valid <= 1'b1;
          link.word <= {10'h0, value[35:18], cur_tag};
          cur_tag <= cur_tag + 4'h1;
          state <= fractal_pkg::SEND_LO;
        end
        fractal_pkg::SEND_LO: begin
          link.word_valid <= 1'b1;
          // leap words carry only ten bits so the half field stays clean above them
          if (cur_tag == `TAG_END) begin
            link.word <= {28'h0, cur_tag};
          end else if (cur_tag == `TAG_A_LEAP || cur_tag == `TAG_B_LEAP) begin
            link.word <= {18'h0, value[9:0], cur_tag};
          end else begin
            link.word <= {10'h0, value[17:0], cur_tag};
          end
          state <= fractal_pkg::SEND_IDLE;
        end
        default: begin
          state <= fractal_pkg::SEND_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      case (araddr)
        `REG_VALUE_HI: rdata <= {28'h0, value_hi};
        `REG_VALUE_LO: rdata <= value_lo;
        `REG_COMMAND: rdata <= 32'h0;
        `REG_STATUS: rdata <= {29'h0, link.gen_done, link.gen_valid, state != fractal_pkg::SEND_IDLE};
        default: begin
          rdata <= 32'h0;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule

// file: include/fractal_map.svh
// offsets, field positions, tag codes and counts shared by both ends
`ifndef FRACTAL_MAP_SVH
`define FRACTAL_MAP_SVH

// ****************************************
// tagged parameter word
// ****************************************
`define TAG_LSB 0
`define TAG_MSB 3
`define HALF_LSB 4
`define HALF_MSB 21
`define LEAP_MSB 13
`define TAG_A_MIN_HI 4'h0
`define TAG_A_MIN_LO 4'h1
`define TAG_A_DIFF_HI 4'h2
`define TAG_A_DIFF_LO 4'h3
`define TAG_A_LEAP 4'h4
`define TAG_B_MIN_HI 4'h5
`define TAG_B_MIN_LO 4'h6
`define TAG_B_DIFF_HI 4'h7
`define TAG_B_DIFF_LO 4'h8
`define TAG_B_LEAP 4'h9
`define TAG_C_REAL_HI 4'hA
`define TAG_C_REAL_LO 4'hB
`define TAG_C_IMG_HI 4'hC
`define TAG_C_IMG_LO 4'hD
`define TAG_END 4'hE

// ****************************************
// window and dispatch
// ****************************************
`define HORIZONTAL_PIXEL_COUNT 10'h280
`define VERTICAL_PIXEL_COUNT 10'h1E0
`define UNIT_COUNT 4

// ****************************************
// host register map
// ****************************************
`define REG_VALUE_HI 4'h0
`define REG_VALUE_LO 4'h4
`define REG_COMMAND 4'h8
`define REG_STATUS 4'hC
`define STATUS_BUSY 0
`define STATUS_VALID 1
`define STATUS_DONE 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************
// host command codes
// ****************************************
`define CMD_A_MIN 4'h0
`define CMD_A_DIFF 4'h1
`define CMD_A_LEAP 4'h2
`define CMD_B_MIN 4'h3
`define CMD_B_DIFF 4'h4
`define CMD_B_LEAP 4'h5
`define CMD_C_REAL 4'h6
`define CMD_C_IMG 4'h7
`define CMD_END 4'h8

`endif

// file: include/fractal_pkg.sv
// types shared by both ends of the parameter link
package fractal_pkg;
  typedef logic [35:0] value_t;
  typedef logic [17:0] half_t;
  typedef logic [9:0] leap_t;
  typedef logic [9:0] index_t;
  typedef logic [3:0] tag_t;
  typedef logic [31:0] word_t;
  typedef enum {SEND_IDLE, SEND_HI, SEND_LO} send_state_t;
endpackage

// file: include/param_link_if.sv
// tagged-word link between the host end and the window dispatcher
`timescale 1ns/100ps
interface param_link_if;
  logic word_valid;
  fractal_pkg::word_t word;
  logic gen_valid;
  logic gen_done;

  modport device (
    input word_valid,
    input word,
    output gen_valid,
    output gen_done
  );

  modport host (
    output word_valid,
    output word,
    input gen_valid,
    input gen_done
  );
endinterface

// file: rtl/diff_counter.sv
// differential counter: walks one axis with adds and compares only
`timescale 1ns/100ps
`include "fractal_map.svh"
module diff_counter #(
  parameter fractal_pkg::index_t COUNT = 10'h280
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // control
  input wire logic init,
  input wire logic advance,
  // setup values
  input wire fractal_pkg::value_t start,
  input wire fractal_pkg::value_t step,
  input wire fractal_pkg::leap_t leap,
  // state
  output fractal_pkg::value_t value,
  output fractal_pkg::index_t index,
  output logic at_max
);
  localparam fractal_pkg::index_t LAST = COUNT - 10'h001;

  fractal_pkg::value_t start_q;
  fractal_pkg::value_t step_q;
  fractal_pkg::leap_t leap_q;
  fractal_pkg::leap_t leap_cnt;
  logic leap_due;
  logic wrap;

  assign leap_due = (leap_q != 10'h000) && (leap_cnt == leap_q - 10'h001);
  assign wrap = (index == LAST);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      start_q <= 36'h0;
      step_q <= 36'h0;
      leap_q <= 10'h000;
    end else if (init) begin
      start_q <= start;
      step_q <= step;
      leap_q <= leap;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      value <= 36'h0;
      index <= 10'h000;
      leap_cnt <= 10'h000;
      at_max <= 1'b0;
    end else if (init) begin
      value <= start;
      index <= 10'h000;
      leap_cnt <= 10'h000;
      at_max <= (LAST == 10'h000);
    end else if (advance) begin
      if (wrap) begin
        value <= start_q;
        index <= 10'h000;
        leap_cnt <= 10'h000;
        at_max <= (LAST == 10'h000);
      end else begin
        value <= value + step_q + {35'h0, leap_due};
        index <= index + 10'h001;
        leap_cnt <= leap_due ? 10'h000 : leap_cnt + 10'h001;
        at_max <= (index + 10'h001 == LAST);
      end
    end
  end
endmodule

// file: rtl/window_dispatch.sv
// window generator and dispatcher: device end of the parameter link
//
// Overview of operation
// - each host word is 32 bits, low nibble tags
// - 36-bit values travel as two 18-bit halves
// - real step lower half uses tag 0011
// - store starts, steps (36 bits), leaps (10 bits)
// - store Julia constant real and imaginary parts
// - axis value built by adding step per index
// - add extra one every leap-interval steps
// - host computes step and leap from span
// - two differential counters, real and imaginary
// - counter loads start, step, leap on reset
// - counter adds step each advance cycle
// - counter flags when final index reached
// - rows advance when column counter wraps
// - valid asserted with the host-issued reset
// - next tuple presented cycle after advance
// - after last pixel flag exhausted, stop
// - current tuple driven to every unit
// - strobe ready unit while data valid
// - advance generator with the load strobe
// - only one unit loaded per tuple
// - window is 640 by 480 pixels
`timescale 1ns/100ps
`include "fractal_map.svh"
module window_dispatch (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // parameter link
  param_link_if.device link,
  // tuple to the escape iteration units
  output fractal_pkg::index_t tuple_x,
  output fractal_pkg::index_t tuple_y,
  output fractal_pkg::value_t tuple_a,
  output fractal_pkg::value_t tuple_b,
  // Julia constant to the escape iteration units
  output fractal_pkg::value_t julia_real,
  output fractal_pkg::value_t julia_img,
  // escape iteration unit handshake
  input wire logic [`UNIT_COUNT-1:0] unit_ready,
  output logic [`UNIT_COUNT-1:0] unit_load
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [`UNIT_COUNT-1:0] lowest_one(input logic [`UNIT_COUNT-1:0] req);
    logic [`UNIT_COUNT-1:0] pick;
    logic found;
    pick = '0;
    found = 1'b0;
    for (int i = 0; i < `UNIT_COUNT; i++) begin
      if (req[i] && !found) begin
        pick[i] = 1'b1;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  function automatic fractal_pkg::value_t join_halves(input fractal_pkg::half_t hi,
                                                       input fractal_pkg::half_t lo);
    return {hi, lo};
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  fractal_pkg::half_t shadow [0:15];
  fractal_pkg::tag_t word_tag;
  fractal_pkg::half_t word_half;
  logic restart;
  fractal_pkg::value_t a_start;
  fractal_pkg::value_t a_step;
  fractal_pkg::leap_t a_leap;
  fractal_pkg::value_t b_start;
  fractal_pkg::value_t b_step;
  fractal_pkg::leap_t b_leap;
  fractal_pkg::value_t a_value;
  fractal_pkg::value_t b_value;
  fractal_pkg::index_t col_index;
  fractal_pkg::index_t row_index;
  logic col_max;
  logic row_max;
  logic valid;
  logic done;
  logic [`UNIT_COUNT-1:0] eligible;
  logic [`UNIT_COUNT-1:0] grant;
  logic advance;
  logic row_advance;

  // ****************************************
  // tagged word capture
  // ****************************************
  assign word_tag = link.word[`TAG_MSB:`TAG_LSB];
  assign word_half = link.word[`HALF_MSB:`HALF_LSB];
  assign restart = link.word_valid && (word_tag == `TAG_END);

  // halves are kept by tag; an end word writes nothing here
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        shadow[i] <= 18'h0;
      end
    end else if (link.word_valid && !restart) begin
      shadow[word_tag] <= word_half;
    end
  end

  // ****************************************
  // parameter assembly
  // ****************************************
  assign a_start = join_halves(shadow[`TAG_A_MIN_HI], shadow[`TAG_A_MIN_LO]);
  assign a_step = join_halves(shadow[`TAG_A_DIFF_HI], shadow[`TAG_A_DIFF_LO]);
  assign a_leap = shadow[`TAG_A_LEAP][9:0];
  assign b_start = join_halves(shadow[`TAG_B_MIN_HI], shadow[`TAG_B_MIN_LO]);
  assign b_step = join_halves(shadow[`TAG_B_DIFF_HI], shadow[`TAG_B_DIFF_LO]);
  assign b_leap = shadow[`TAG_B_LEAP][9:0];

  // the constant changes only on an end word, never mid-window
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      julia_real <= 36'h0;
      julia_img <= 36'h0;
    end else if (restart) begin
      julia_real <= join_halves(shadow[`TAG_C_REAL_HI], shadow[`TAG_C_REAL_LO]);
      julia_img <= join_halves(shadow[`TAG_C_IMG_HI], shadow[`TAG_C_IMG_LO]);
    end
  end

  // ****************************************
  // coordinate counters
  // ****************************************
  assign row_advance = advance && col_max;

  diff_counter #(
    .COUNT(`HORIZONTAL_PIXEL_COUNT)
  ) col_counter (
    .mclk(mclk),
    .resetn(resetn),
    .init(restart),
    .advance(advance),
    .start(a_start),
    .step(a_step),
    .leap(a_leap),
    .value(a_value),
    .index(col_index),
    .at_max(col_max)
  );

  diff_counter #(
    .COUNT(`VERTICAL_PIXEL_COUNT)
  ) row_counter (
    .mclk(mclk),
    .resetn(resetn),
    .init(restart),
    .advance(row_advance),
    .start(b_start),
    .step(b_step),
    .leap(b_leap),
    .value(b_value),
    .index(row_index),
    .at_max(row_max)
  );

  // ****************************************
  // generator flags
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      valid <= 1'b0;
      done <= 1'b0;
    end else if (restart) begin
      valid <= 1'b1;
      done <= 1'b0;
    end else if (advance && col_max && row_max) begin
      valid <= 1'b0;
      done <= 1'b1;
    end
  end

  assign link.gen_valid = valid;
  assign link.gen_done = done;

  // ****************************************
  // dispatch
  // ****************************************
  // a unit strobed last cycle still shows ready until it sees the strobe
  assign eligible = unit_ready & ~unit_load;
  assign grant = valid ? lowest_one(eligible) : '0;
  assign advance = |grant;

  // the registered tuple lines up with the strobe one edge later
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tuple_x <= 10'h000;
      tuple_y <= 10'h000;
      tuple_a <= 36'h0;
      tuple_b <= 36'h0;
    end else begin
      tuple_x <= col_index;
      tuple_y <= row_index;
      tuple_a <= a_value;
      tuple_b <= b_value;
    end
  end

  generate
    for (genvar u = 0; u < `UNIT_COUNT; u++) begin : g_load
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          unit_load[u] <= 1'b0;
        end else begin
          unit_load[u] <= grant[u];
        end
      end
    end
  endgenerate

endmodule

// file: tb/param_link_chk.sv
// assertions on the tagged-word link between the host end and the dispatcher
`timescale 1ns/100ps
`include "fractal_map.svh"
module param_link_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link signals
  input wire logic word_valid,
  input wire fractal_pkg::word_t word,
  input wire logic gen_valid,
  input wire logic gen_done
);
  wire fractal_pkg::tag_t tag = word[3:0];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  AST_TAG_KNOWN: assert property (word_valid |-> tag <= `TAG_END)
    else $error("link word carries an unknown tag");
  AST_UPPER_ZERO: assert property (word_valid |-> word[31:22] == 10'h0)
    else $error("link word has bits set above the half field");
  AST_LEAP_WIDTH: assert property (word_valid && tag inside {`TAG_A_LEAP, `TAG_B_LEAP} |-> word[21:14] == 8'h0)
    else $error("leap word wider than ten bits");
  AST_LO_AFTER_HI: assert property (word_valid && tag inside {4'h0, 4'h2, 4'h5, 4'h7, 4'hA, 4'hC}
    |=> word_valid && tag == $past(tag) + 4'h1)
    else $error("upper half not followed by its lower half");
  AST_DIFF_LO_TAG: assert property (word_valid && tag == `TAG_A_DIFF_HI |=> tag == 4'h3)
    else $error("real step lower half has the wrong tag");
  AST_LO_HAS_HI: assert property (word_valid && tag inside {4'h1, 4'h3, 4'h6, 4'h8, 4'hB, 4'hD}
    |-> $past(word_valid) && $past(tag) == tag - 4'h1)
    else $error("lower half sent without its upper half");
  AST_END_STARTS: assert property (word_valid && tag == `TAG_END |=> gen_valid && !gen_done)
    else $error("end word did not start generation");
  AST_START_NEEDS_END: assert property ($rose(gen_valid) |-> $past(word_valid) && $past(tag) == `TAG_END)
    else $error("generation started without an end word");
  AST_DONE_EXCLUSIVE: assert property (gen_done |-> !gen_valid)
    else $error("exhausted generator still flags valid data");
  AST_DONE_HOLDS: assert property (gen_done && !(word_valid && tag == `TAG_END) |=> gen_done)
    else $error("exhausted flag dropped without a restart");
  AST_DONE_FOLLOWS_VALID: assert property ($rose(gen_done) |-> $past(gen_valid))
    else $error("exhausted flag rose while idle");
endmodule

// file: tb/fractal_window_dispatch_tb.sv
// self-checking bench: host end and dispatcher joined over the tagged-word link
`timescale 1ns/100ps
`include "fractal_map.svh"
module fractal_window_dispatch_tb;
  localparam fractal_pkg::value_t vals [8] = '{36'hF00000123, 36'h000401001, 36'h000000C03, 36'h123456789,
    36'h000030005, 36'h000000002, 36'hABCDEF012, 36'h543210FED};
  localparam fractal_pkg::tag_t hi_tags [8] = '{`TAG_A_MIN_HI, `TAG_A_DIFF_HI, `TAG_A_LEAP, `TAG_B_MIN_HI,
    `TAG_B_DIFF_HI, `TAG_B_LEAP, `TAG_C_REAL_HI, `TAG_C_IMG_HI};
  localparam logic [3:0] ready_tab [4] = '{4'hF, 4'hA, 4'h6, 4'h8};
  logic mclk;
  logic resetn;
  logic awvalid;
  logic awready;
  logic [3:0] awaddr;
  logic wvalid;
  logic wready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic bvalid;
  logic bready;
  logic [1:0] bresp;
  logic arvalid;
  logic arready;
  logic [3:0] araddr;
  logic rvalid;
  logic rready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  fractal_pkg::index_t tuple_x;
  fractal_pkg::index_t tuple_y;
  fractal_pkg::value_t tuple_a;
  fractal_pkg::value_t tuple_b;
  fractal_pkg::value_t julia_real;
  fractal_pkg::value_t julia_img;
  logic [`UNIT_COUNT-1:0] unit_ready;
  logic [`UNIT_COUNT-1:0] unit_load;
  fractal_pkg::word_t words [$];
  int fails = 0;
  int samples_checked = 0;

  param_link_if link ();
  param_host u_param_host (.mclk(mclk), .resetn(resetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .link(link));
  window_dispatch u_window_dispatch (.mclk(mclk), .resetn(resetn), .link(link), .tuple_x(tuple_x),
    .tuple_y(tuple_y), .tuple_a(tuple_a), .tuple_b(tuple_b), .julia_real(julia_real), .julia_img(julia_img),
    .unit_ready(unit_ready), .unit_load(unit_load));
  param_link_chk u_param_link_chk (.mclk(mclk), .resetn(resetn), .word_valid(link.word_valid),
    .word(link.word), .gen_valid(link.gen_valid), .gen_done(link.gen_done));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (link.word_valid === 1'b1) words.push_back(link.word);
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask

  task automatic axi_write(input logic [3:0] addr, input logic [31:0] data, output logic [1:0] resp);
    int n;
    @(posedge mclk);
    awaddr <= addr;
    wdata <= data;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 100);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 100) begin
      fails++;
      summarize();
    end
  endtask

  task automatic axi_read(input logic [3:0] addr, output logic [31:0] data, output logic [1:0] resp);
    int n;
    @(posedge mclk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 100);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 100) begin
      fails++;
      summarize();
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic regs_after_reset;
    logic [31:0] d;
    logic [1:0] r;
    axi_read(`REG_STATUS, d, r);
    check(d, 32'h0);
    axi_read(`REG_COMMAND, d, r);
    check({r, d}, {`RESP_OKAY, 32'h0});
    axi_read(4'h2, d, r);
    check({r, d}, {`RESP_SLVERR, 32'h0});
    axi_write(`REG_STATUS, 32'h7, r);
    check(r, `RESP_SLVERR);
    axi_write(4'h6, 32'h1, r);
    check(r, `RESP_SLVERR);
    check(link.gen_valid, 1'b0);
  endtask

  task automatic send_value(input logic [3:0] cmd, input fractal_pkg::value_t v);
    logic [1:0] r;
    fractal_pkg::tag_t tg;
    words.delete();
    tg = hi_tags[cmd];
    axi_write(`REG_VALUE_HI, {28'h0, v[35:32]}, r);
    axi_write(`REG_VALUE_LO, v[31:0], r);
    axi_write(`REG_COMMAND, {28'h0, cmd}, r);
    check(r, `RESP_OKAY);
    repeat (3) @(posedge mclk);
    if (cmd == `CMD_A_LEAP || cmd == `CMD_B_LEAP) begin
      check(words.size(), 1);
      check(words[0], {18'h0, v[9:0], tg});
    end else begin
      check(words.size(), 2);
      check(words[0], {10'h0, v[35:18], tg});
      check(words[1], {10'h0, v[17:0], tg + 4'h1});
    end
  endtask

  task automatic load_window;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 8; i++) send_value(4'(i), vals[i]);
    axi_read(`REG_STATUS, d, r);
    check(d, 32'h0);
    axi_read(`REG_VALUE_HI, d, r);
    check({r, d}, {`RESP_OKAY, 28'h0, vals[7][35:32]});
    axi_read(`REG_VALUE_LO, d, r);
    check({r, d}, {`RESP_OKAY, vals[7][31:0]});
    words.delete();
    axi_write(`REG_COMMAND, {28'h0, `CMD_END}, r);
    repeat (3) @(posedge mclk);
    check(words.size(), 1);
    check(words[0], {28'h0, `TAG_END});
    check(link.gen_valid, 1'b1);
    check(julia_real, vals[6]);
    check(julia_img, vals[7]);
    axi_read(`REG_STATUS, d, r);
    check(d, 32'h2);
  endtask

  task automatic dispatch(input int cycles, input int p0);
    int p;
    int x;
    int y;
    logic [3:0] avail;
    logic [3:0] exp_load;
    p = p0;
    exp_load = 4'h0;
    for (int c = 0; c < cycles; c++) begin
      @(posedge mclk);
      check(unit_load, exp_load);
      if (unit_load !== 4'h0) begin
        x = p % `HORIZONTAL_PIXEL_COUNT;
        y = p / `HORIZONTAL_PIXEL_COUNT;
        check({tuple_y, tuple_x}, {10'(y), 10'(x)});
        check(tuple_a, vals[0] + 36'(x) * vals[1] + 36'(x / 3));
        check(tuple_b, vals[3] + 36'(y) * vals[4] + 36'(y / 2));
        p++;
      end
      avail = unit_ready & ~unit_load;
      exp_load = 4'h0;
      for (int i = 3; i >= 0; i--) begin
        if (link.gen_valid && avail[i]) exp_load = 4'h1 << i;
      end
      unit_ready <= (c % 16 < 2) ? 4'h0 : ready_tab[c % 4];
    end
    if (cycles > 700) check(p > `HORIZONTAL_PIXEL_COUNT, 1'b1);
  endtask

  task automatic restart_mid_run;
    logic [1:0] r;
    @(posedge mclk);
    unit_ready <= 4'h0;
    repeat (2) @(posedge mclk);
    axi_write(`REG_COMMAND, {28'h0, `CMD_END}, r);
    repeat (3) @(posedge mclk);
    check(link.gen_valid, 1'b1);
    dispatch(40, 0);
  endtask

  initial begin
    resetn = 1'b0;
    awvalid = 1'b0;
    awaddr = 4'h0;
    wvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    bready = 1'b0;
    arvalid = 1'b0;
    araddr = 4'h0;
    rready = 1'b0;
    unit_ready = 4'h0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    regs_after_reset();
    load_window();
    dispatch(800, 0);
    restart_mid_run();
    summarize();
  end
endmodule
